/* File: rtl/sbmcr_pkg.sv */
/*
  sbmcr_pkg: offsets, field positions, reset values and codes shared by the
  misc configuration register slice and its helpers.
  assumes: byte-wide configuration access, one byte per offset.
*/
package sbmcr_pkg;
  // ------------------------------------------------------------------
  // register offsets (byte addresses in configuration space)
  // ------------------------------------------------------------------
  localparam logic [7:0] OFF_SER1_DMA = 8'hba;
  localparam logic [7:0] OFF_SER2_DMA = 8'hbb;
  localparam logic [7:0] OFF_FLASH_B0 = 8'hbc;
  localparam logic [7:0] OFF_FLASH_B1 = 8'hbd;
  localparam logic [7:0] OFF_FLASH_B2 = 8'hbe;
  localparam logic [7:0] OFF_PCAP_B0 = 8'hc0;
  localparam logic [7:0] OFF_PCAP_B1 = 8'hc1;
  localparam logic [7:0] OFF_PCAP_B2 = 8'hc2;
  localparam logic [7:0] OFF_PCAP_B3 = 8'hc3;
  localparam logic [7:0] OFF_PSTATE_B0 = 8'hc4;
  localparam logic [7:0] OFF_SMB_IO_B0 = 8'hd0;
  localparam logic [7:0] OFF_SMB_IO_B1 = 8'hd1;
  localparam logic [7:0] OFF_SMB_CFG = 8'hd2;
  localparam logic [7:0] OFF_SMB_SCMD = 8'hd3;
  localparam logic [7:0] OFF_SMB_SP1 = 8'hd4;
  localparam logic [7:0] OFF_SMB_SP2 = 8'hd5;
  localparam logic [7:0] OFF_SMB_REV = 8'hd6;
  localparam logic [7:0] OFF_EDGE_SEL = 8'he0;
  localparam logic [7:0] OFF_EVT_STATUS = 8'hf0;
  localparam logic [7:0] OFF_EVT_CLEAR = 8'hf1;
  localparam logic [7:0] OFF_EVT_ENABLE = 8'hf2;

  // ------------------------------------------------------------------
  // fixed values and reset values
  // ------------------------------------------------------------------
  localparam logic [31:0] PCAP_WORD = 32'h0002_0001;
  localparam logic [3:0] SMB_IO_LOW_FIXED = 4'h1;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [1:0] PSTATE_D0 = 2'h0;
  localparam logic [1:0] PSTATE_D3 = 2'h3;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int DMA_RX_LSB = 4;
  localparam int DMA_TX_LSB = 0;
  localparam int SMB_CFG_EN = 0;
  localparam int SMB_CFG_IRQ = 1;
  localparam int SMB_CFG_CLK128 = 2;
  localparam int SMB_CFG_ROUTE = 3;
  localparam logic [7:0] SMB_CFG_WMASK = 8'h0f;
  localparam logic [7:0] FLASH_B0_WMASK = 8'hf0;
  localparam int NUM_GPI = 8;

  // reference divider for the 128K smbus source from 14.318 MHz
  localparam int REF_HZ = 14318000;
  localparam int SLOW_HZ = 128000;
  localparam int REF_DIV = REF_HZ / (2 * SLOW_HZ);

  // status bits of the event block
  localparam int EVT_GPI = 0;
  localparam int EVT_PSTATE = 1;
  localparam int EVT_W = 2;
endpackage

/* File: rtl/sbmcr_dma_dec.sv */
/*
  sbmcr_dma_dec: decodes one 3-bit dma channel select into a one-hot
  channel vector.
  assumes: code comes straight from a register on the same clock.
*/
`timescale 1ns/1ps
module sbmcr_dma_dec (
  input wire logic [2:0] code,
  output logic [3:0] chan_onehot,
  output logic chan_valid
);
  // ------------------------------------------------------------------
  // decode
  // ------------------------------------------------------------------
  // top bit set means a channel; reserved codes select nothing
  always_comb begin
    chan_onehot = 4'h0;
    chan_valid = code[2];
    if (code[2]) begin
      chan_onehot[code[1:0]] = 1'b1;
    end
  end
endmodule

/* File: rtl/sbmcr_edge_det.sv */
/*
  sbmcr_edge_det: two-flop synchroniser plus selectable edge detector for
  a group of general-purpose inputs.
  assumes: pins are asynchronous to core_clk; pulses need input stable
  for at least one clock to be seen.
*/
`timescale 1ns/1ps
module sbmcr_edge_det #(
  parameter int WIDTH = 8
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] pin_in,
  input wire logic [WIDTH-1:0] rise_sel,
  output logic [WIDTH-1:0] edge_pulse
);
  logic [WIDTH-1:0] meta_reg, meta_next;
  logic [WIDTH-1:0] sync_reg, sync_next;
  logic [WIDTH-1:0] prev_reg, prev_next;
  logic [WIDTH-1:0] pulse_reg, pulse_next;

  if (WIDTH < 1) begin : g_width_check
    $error("width must be positive");
  end

  // ------------------------------------------------------------------
  // synchronise and compare with the previous sample
  // ------------------------------------------------------------------
  // meta_reg is read only by sync_reg to keep the chain clean
  always_comb begin
    meta_next = pin_in;
    sync_next = meta_reg;
    prev_next = sync_reg;
    for (int i = 0; i < WIDTH; i++) begin
      pulse_next[i] = rise_sel[i] ? (sync_reg[i] & ~prev_reg[i])
                                  : (~sync_reg[i] & prev_reg[i]);
    end
  end

  // reset clears the chain; select resets to falling, so a high pin gives no pulse
  always_ff @(posedge core_clk) begin
    if (srst) begin
      meta_reg <= '0;
      sync_reg <= '0;
      prev_reg <= '0;
      pulse_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      prev_reg <= prev_next;
      pulse_reg <= pulse_next;
    end
  end

  assign edge_pulse = pulse_reg;
endmodule

/* File: rtl/sbmcr_regs.sv */
/*
  sbmcr_regs: misc configuration register slice of a south-bridge bus
  function: serial dma channel selects, flash window base, power
  capability and state, smbus host configuration, input edge selects,
  plus an event status / clear / enable block with one interrupt.
  assumes: byte-wide register port, one-cycle strobes, read data one
  cycle after the read strobe; gpi pins asynchronous to core_clk.

// Function
// - port one rx dma select bits 6:4: 000 none, 100-111 channels 0-3
// - port one tx dma select bits 2:0, same encoding
// - port two rx and tx selects use the same encoding
// - flash window bits 23:4 hold address 31:12; bits 3:0 read zero
// - fixed capability word: id 01h, next zero, upper 0002h
// - power state bits 1:0, 00 D0, 11 D3; other bits zero
// - smbus io base bits 15:4 writable; bits 3:0 read 1h
// - alert routes to system-mgmt when bit3 is 0, config-event when 1
// - bit2 selects 128K clock divided from the 14.318 MHz reference
// - bit0 enables host, bit1 enables irq; bits 7:4 read zero
// - 8-bit host slave command, read/write
// - shadow ports: address bits 7:1, direction bit 0 (1 write)
// - edge select: 0 falling, 1 rising, per general input
*/
`timescale 1ns/1ps
module sbmcr_regs #(
  parameter logic [7:0] SMB_REV_CODE = 8'h5a, // arbitrary value
  parameter int GPI_W = sbmcr_pkg::NUM_GPI
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic ref_clk_in,
  input wire logic [GPI_W-1:0] gpi_pins,
  input wire logic smb_alert,
  output logic [3:0] serial_port_one_rx_dma,
  output logic [3:0] serial_port_one_tx_dma,
  output logic [3:0] serial_port_two_rx_dma,
  output logic [3:0] serial_port_two_tx_dma,
  output logic [31:0] flash_window_addr,
  output logic [1:0] power_state,
  output logic [15:0] smb_io_base,
  output logic smb_host_enable,
  output logic smb_clk_slow_sel,
  output logic smb_slow_tick,
  output logic [7:0] smb_slave_cmd,
  output logic [6:0] shadow1_addr,
  output logic shadow1_write,
  output logic [6:0] shadow2_addr,
  output logic shadow2_write,
  output logic system_mgmt_interrupt,
  output logic config_event_interrupt,
  output logic [GPI_W-1:0] gpi_event,
  output logic irq
);
  if (GPI_W != sbmcr_pkg::NUM_GPI) begin : g_gpi_w_check
    $error("gpi width must match edge register");
  end

  // ------------------------------------------------------------------
  // register state
  // ------------------------------------------------------------------
  logic [7:0] ser1_reg, ser1_next;
  logic [7:0] ser2_reg, ser2_next;
  logic [23:0] flash_reg, flash_next;
  logic [1:0] pstate_reg, pstate_next;
  logic [15:4] smbio_reg, smbio_next;
  logic [3:0] smbcfg_reg, smbcfg_next;
  logic [7:0] scmd_reg, scmd_next;
  logic [7:0] sp1_reg, sp1_next;
  logic [7:0] sp2_reg, sp2_next;
  logic [7:0] edge_reg, edge_next;
  logic [sbmcr_pkg::EVT_W-1:0] st_reg, st_next;
  logic [sbmcr_pkg::EVT_W-1:0] en_reg, en_next;
  logic [7:0] rdata_reg, rdata_next;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  logic [GPI_W-1:0] gpi_pulse;
  logic [sbmcr_pkg::EVT_W-1:0] evt_set, evt_clr;
  logic pstate_wr;
  logic wr_ok_pstate;

  // ------------------------------------------------------------------
  // write side
  // ------------------------------------------------------------------
  // power state only accepts the two defined codes; others are dropped
  assign wr_ok_pstate = (reg_wdata[1:0] == sbmcr_pkg::PSTATE_D0) ||
                        (reg_wdata[1:0] == sbmcr_pkg::PSTATE_D3);
  assign pstate_wr = reg_wr && hit(reg_addr, sbmcr_pkg::OFF_PSTATE_B0) && wr_ok_pstate;

  always_comb begin
    ser1_next = ser1_reg;
    ser2_next = ser2_reg;
    flash_next = flash_reg;
    pstate_next = pstate_reg;
    smbio_next = smbio_reg;
    smbcfg_next = smbcfg_reg;
    scmd_next = scmd_reg;
    sp1_next = sp1_reg;
    sp2_next = sp2_reg;
    edge_next = edge_reg;
    en_next = en_reg;
    if (reg_wr) begin
      unique case (reg_addr)
        sbmcr_pkg::OFF_SER1_DMA: ser1_next = reg_wdata;
        sbmcr_pkg::OFF_SER2_DMA: ser2_next = reg_wdata;
        sbmcr_pkg::OFF_FLASH_B0: begin
          flash_next[7:0] = reg_wdata & sbmcr_pkg::FLASH_B0_WMASK;
        end
        sbmcr_pkg::OFF_FLASH_B1: flash_next[15:8] = reg_wdata;
        sbmcr_pkg::OFF_FLASH_B2: flash_next[23:16] = reg_wdata;
        sbmcr_pkg::OFF_PSTATE_B0: begin
          if (pstate_wr) begin
            pstate_next = reg_wdata[1:0];
          end
        end
        sbmcr_pkg::OFF_SMB_IO_B0: smbio_next[7:4] = reg_wdata[7:4];
        sbmcr_pkg::OFF_SMB_IO_B1: smbio_next[15:8] = reg_wdata;
        sbmcr_pkg::OFF_SMB_CFG: begin
          smbcfg_next = reg_wdata[3:0];
        end
        sbmcr_pkg::OFF_SMB_SCMD: scmd_next = reg_wdata;
        sbmcr_pkg::OFF_SMB_SP1: sp1_next = reg_wdata;
        sbmcr_pkg::OFF_SMB_SP2: sp2_next = reg_wdata;
        sbmcr_pkg::OFF_EDGE_SEL: edge_next = reg_wdata;
        sbmcr_pkg::OFF_EVT_ENABLE: en_next = reg_wdata[sbmcr_pkg::EVT_W-1:0];
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // event status: set wins over a clear in the same cycle
  // ------------------------------------------------------------------
  assign evt_set[sbmcr_pkg::EVT_GPI] = |gpi_pulse;
  assign evt_set[sbmcr_pkg::EVT_PSTATE] = pstate_wr && (reg_wdata[1:0] != pstate_reg);
  assign evt_clr = (reg_wr && hit(reg_addr, sbmcr_pkg::OFF_EVT_CLEAR)) ?
                   reg_wdata[sbmcr_pkg::EVT_W-1:0] : '0;

  always_comb begin
    st_next = (st_reg & ~evt_clr) | evt_set;
  end

  // ------------------------------------------------------------------
  // read side: data valid the cycle after the strobe, only then
  // ------------------------------------------------------------------
  always_comb begin
    rdata_next = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        sbmcr_pkg::OFF_SER1_DMA: rdata_next = ser1_reg;
        sbmcr_pkg::OFF_SER2_DMA: rdata_next = ser2_reg;
        sbmcr_pkg::OFF_FLASH_B0: rdata_next = flash_reg[7:0];
        sbmcr_pkg::OFF_FLASH_B1: rdata_next = flash_reg[15:8];
        sbmcr_pkg::OFF_FLASH_B2: rdata_next = flash_reg[23:16];
        sbmcr_pkg::OFF_PCAP_B0: rdata_next = sbmcr_pkg::PCAP_WORD[7:0];
        sbmcr_pkg::OFF_PCAP_B1: rdata_next = sbmcr_pkg::PCAP_WORD[15:8];
        sbmcr_pkg::OFF_PCAP_B2: rdata_next = sbmcr_pkg::PCAP_WORD[23:16];
        sbmcr_pkg::OFF_PCAP_B3: rdata_next = sbmcr_pkg::PCAP_WORD[31:24];
        sbmcr_pkg::OFF_PSTATE_B0: rdata_next = {6'h00, pstate_reg};
        sbmcr_pkg::OFF_SMB_IO_B0: begin
          rdata_next = {smbio_reg[7:4], sbmcr_pkg::SMB_IO_LOW_FIXED};
        end
        sbmcr_pkg::OFF_SMB_IO_B1: rdata_next = smbio_reg[15:8];
        sbmcr_pkg::OFF_SMB_CFG: rdata_next = {4'h0, smbcfg_reg};
        sbmcr_pkg::OFF_SMB_SCMD: rdata_next = scmd_reg;
        sbmcr_pkg::OFF_SMB_SP1: rdata_next = sp1_reg;
        sbmcr_pkg::OFF_SMB_SP2: rdata_next = sp2_reg;
        sbmcr_pkg::OFF_SMB_REV: rdata_next = SMB_REV_CODE;
        sbmcr_pkg::OFF_EDGE_SEL: rdata_next = edge_reg;
        sbmcr_pkg::OFF_EVT_STATUS: rdata_next = 8'(st_reg);
        sbmcr_pkg::OFF_EVT_ENABLE: rdata_next = 8'(en_reg);
        default: rdata_next = 8'h00; // unmapped and write-only read zero
      endcase
    end
  end

  // ------------------------------------------------------------------
  // register update
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ser1_reg <= sbmcr_pkg::RESET_BYTE;
      ser2_reg <= sbmcr_pkg::RESET_BYTE;
      flash_reg <= 24'h000000;
      pstate_reg <= sbmcr_pkg::PSTATE_D0;
      smbio_reg <= 12'h000;
      smbcfg_reg <= 4'h0;
      scmd_reg <= sbmcr_pkg::RESET_BYTE;
      sp1_reg <= sbmcr_pkg::RESET_BYTE;
      sp2_reg <= sbmcr_pkg::RESET_BYTE;
      edge_reg <= sbmcr_pkg::RESET_BYTE;
      st_reg <= '0;
      en_reg <= '0;
      rdata_reg <= 8'h00;
    end else begin
      ser1_reg <= ser1_next;
      ser2_reg <= ser2_next;
      flash_reg <= flash_next;
      pstate_reg <= pstate_next;
      smbio_reg <= smbio_next;
      smbcfg_reg <= smbcfg_next;
      scmd_reg <= scmd_next;
      sp1_reg <= sp1_next;
      sp2_reg <= sp2_next;
      edge_reg <= edge_next;
      st_reg <= st_next;
      en_reg <= en_next;
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign irq = |(st_reg & en_reg);

  // ------------------------------------------------------------------
  // dma channel decode
  // ------------------------------------------------------------------
  sbmcr_dma_dec u_s1rx (
    .code(ser1_reg[sbmcr_pkg::DMA_RX_LSB +: 3]),
    .chan_onehot(serial_port_one_rx_dma),
    .chan_valid()
  );
  sbmcr_dma_dec u_s1tx (
    .code(ser1_reg[sbmcr_pkg::DMA_TX_LSB +: 3]),
    .chan_onehot(serial_port_one_tx_dma),
    .chan_valid()
  );
  sbmcr_dma_dec u_s2rx (
    .code(ser2_reg[sbmcr_pkg::DMA_RX_LSB +: 3]),
    .chan_onehot(serial_port_two_rx_dma),
    .chan_valid()
  );
  sbmcr_dma_dec u_s2tx (
    .code(ser2_reg[sbmcr_pkg::DMA_TX_LSB +: 3]),
    .chan_onehot(serial_port_two_tx_dma),
    .chan_valid()
  );

  // ------------------------------------------------------------------
  // outputs that steer neighbouring blocks
  // ------------------------------------------------------------------
  assign flash_window_addr = {flash_reg[23:4], 12'h000};
  assign power_state = pstate_reg;
  assign smb_io_base = {smbio_reg, 4'h0};
  assign smb_host_enable = smbcfg_reg[sbmcr_pkg::SMB_CFG_EN];
  assign smb_clk_slow_sel = smbcfg_reg[sbmcr_pkg::SMB_CFG_CLK128];
  assign smb_slave_cmd = scmd_reg;
  assign shadow1_addr = sp1_reg[7:1];
  assign shadow1_write = sp1_reg[0];
  assign shadow2_addr = sp2_reg[7:1];
  assign shadow2_write = sp2_reg[0];

  // ------------------------------------------------------------------
  // smbus alert routing, gated by host irq enable
  // ------------------------------------------------------------------
  logic alert_meta_reg, alert_sync_reg;
  logic alert_gated;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      alert_meta_reg <= 1'b0;
      alert_sync_reg <= 1'b0;
    end else begin
      alert_meta_reg <= smb_alert;
      alert_sync_reg <= alert_meta_reg;
    end
  end
  assign alert_gated = alert_sync_reg && smbcfg_reg[sbmcr_pkg::SMB_CFG_IRQ];
  assign system_mgmt_interrupt = alert_gated && !smbcfg_reg[sbmcr_pkg::SMB_CFG_ROUTE];
  assign config_event_interrupt = alert_gated && smbcfg_reg[sbmcr_pkg::SMB_CFG_ROUTE];

  // ------------------------------------------------------------------
  // 128K tick from the reference: the reference is sampled, so core_clk
  // must run well above twice the reference rate for exact counts
  // ------------------------------------------------------------------
  logic [2:0] ref_sync_reg;
  logic [7:0] div_reg, div_next;
  logic tick_reg, tick_next;
  logic ref_rise;
  assign ref_rise = ref_sync_reg[1] & ~ref_sync_reg[2];
  always_comb begin
    div_next = div_reg;
    tick_next = 1'b0;
    if (smbcfg_reg[sbmcr_pkg::SMB_CFG_CLK128] && ref_rise) begin
      if (div_reg == 8'(sbmcr_pkg::REF_DIV - 1)) begin
        div_next = 8'h00;
        tick_next = 1'b1;
      end else begin
        div_next = div_reg + 8'h01;
      end
    end
  end
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ref_sync_reg <= 3'h0;
      div_reg <= 8'h00;
      tick_reg <= 1'b0;
    end else begin
      ref_sync_reg <= {ref_sync_reg[1:0], ref_clk_in};
      div_reg <= div_next;
      tick_reg <= tick_next;
    end
  end
  assign smb_slow_tick = tick_reg;

  // ------------------------------------------------------------------
  // general input edge events
  // ------------------------------------------------------------------
  sbmcr_edge_det #(.WIDTH(GPI_W)) u_edge (
    .core_clk(core_clk),
    .srst(srst),
    .pin_in(gpi_pins),
    .rise_sel(edge_reg),
    .edge_pulse(gpi_pulse)
  );
  assign gpi_event = gpi_pulse;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  AST_PCAP_FIXED: assert property (@(posedge core_clk) disable iff (srst)
    reg_rd && reg_addr == sbmcr_pkg::OFF_PCAP_B0 |=> reg_rdata == 8'h01)
    else $error("capability id wrong");
  AST_IO_LOW: assert property (@(posedge core_clk) disable iff (srst)
    reg_rd && reg_addr == sbmcr_pkg::OFF_SMB_IO_B0 |=> reg_rdata[3:0] == 4'h1)
    else $error("io base low nibble not 1h");
  AST_FLASH_LOW: assert property (@(posedge core_clk) disable iff (srst)
    flash_window_addr[11:0] == 12'h000 && flash_reg[3:0] == 4'h0)
    else $error("flash window not 4k aligned");
  AST_PSTATE_CODE: assert property (@(posedge core_clk) disable iff (srst)
    pstate_reg == 2'h0 || pstate_reg == 2'h3)
    else $error("power state holds illegal code");
  AST_ROUTE: assert property (@(posedge core_clk) disable iff (srst)
    !(system_mgmt_interrupt && config_event_interrupt))
    else $error("alert routed twice");
  AST_CFG_HI: assert property (@(posedge core_clk) disable iff (srst)
    reg_rd && reg_addr == sbmcr_pkg::OFF_SMB_CFG |=> reg_rdata[7:4] == 4'h0)
    else $error("host config high bits not zero");
  AST_SCMD_RB: assert property (@(posedge core_clk) disable iff (srst)
    reg_wr && reg_addr == sbmcr_pkg::OFF_SMB_SCMD |=> smb_slave_cmd == $past(reg_wdata))
    else $error("slave command readback wrong");
  AST_DMA_DEC: assert property (@(posedge core_clk) disable iff (srst)
    (ser1_reg[6:4] == 3'h5 |-> serial_port_one_rx_dma == 4'h2) and
    (ser1_reg[2] == 1'b0 |-> serial_port_one_tx_dma == 4'h0))
    else $error("dma channel decode wrong");
  AST_SHADOW: assert property (@(posedge core_clk) disable iff (srst)
    reg_wr && reg_addr == sbmcr_pkg::OFF_SMB_SP1 |=> shadow1_write == $past(reg_wdata[0]))
    else $error("shadow direction wrong");
  AST_EDGE_RISE: assert property (@(posedge core_clk) disable iff (srst)
    gpi_pulse[0] |-> $past(gpi_pins[0], 3) == $past(edge_reg[0]) &&
    $past(gpi_pins[0], 4) != $past(edge_reg[0]))
    else $error("edge pulse without edge");
  AST_IRQ: assert property (@(posedge core_clk) disable iff (srst)
    evt_set[0] && en_reg[0] && !(reg_wr && hit(reg_addr, sbmcr_pkg::OFF_EVT_ENABLE)) |=> irq)
    else $error("enabled event gave no interrupt");
  COV_DMA: cover property (@(posedge core_clk) serial_port_two_tx_dma == 4'h8);
  COV_IRQ: cover property (@(posedge core_clk) irq);
  COV_TICK: cover property (@(posedge core_clk) smb_slow_tick);
endmodule

/* File: test/sbmcr_regs_tb_top.sv */
/*
  sbmcr_regs_tb_top: self-checking bench for the misc configuration register slice.
  assumes: sbmcr_pkg and the design files are compiled first; byte port, read data one cycle late.
*/
`timescale 1ns/1ps
module sbmcr_regs_tb_top;
  // ------------------------------------------------------------------
  // signals and reference model
  // ------------------------------------------------------------------
  logic core_clk, srst, reg_wr, reg_rd, ref_clk_in, smb_alert;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, gpi_pins, gpi_event, slave_cmd, v;
  logic [3:0] s1rx, s1tx, s2rx, s2tx;
  logic [31:0] flash_addr;
  logic [15:0] io_base;
  logic [1:0] pstate;
  logic [6:0] sh1_a, sh2_a;
  logic host_en, slow_sel, slow_tick, sys_int, cfg_int, irq, sh1_w, sh2_w;
  logic [7:0] m [256];
  logic [7:0] wm [256];
  logic [7:0] alist [19] = '{8'hba, 8'hbb, 8'hbc, 8'hbd, 8'hbe, 8'hd0, 8'hd1, 8'hd2, 8'hd3,
    8'hd4, 8'hd5, 8'he0, 8'hc0, 8'hc1, 8'hc2, 8'hc3, 8'hc4, 8'hd6, 8'h80};
  logic [7:0] a;
  int bad_count, samples_checked, seed, n;

  sbmcr_regs #(.SMB_REV_CODE(8'h3c)) sbmcr_regs_i ( // revision value arbitrary
    .core_clk(core_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ref_clk_in(ref_clk_in),
    .gpi_pins(gpi_pins), .smb_alert(smb_alert), .serial_port_one_rx_dma(s1rx),
    .serial_port_one_tx_dma(s1tx), .serial_port_two_rx_dma(s2rx),
    .serial_port_two_tx_dma(s2tx), .flash_window_addr(flash_addr), .power_state(pstate),
    .smb_io_base(io_base), .smb_host_enable(host_en), .smb_clk_slow_sel(slow_sel),
    .smb_slow_tick(slow_tick), .smb_slave_cmd(slave_cmd), .shadow1_addr(sh1_a),
    .shadow1_write(sh1_w), .shadow2_addr(sh2_a), .shadow2_write(sh2_w),
    .system_mgmt_interrupt(sys_int), .config_event_interrupt(cfg_int),
    .gpi_event(gpi_event), .irq(irq));

  // clocks: reference is unrelated in phase to core_clk
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  initial begin
    ref_clk_in = 1'b0;
    forever #34.92 ref_clk_in = ~ref_clk_in;
  end

  // ------------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------------
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // model keeps only writable bits; power state takes only the two legal codes
  task automatic wr(logic [7:0] ad, logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= ad;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    if (ad == 8'hc4) begin
      if (d[1:0] == 2'h0 || d[1:0] == 2'h3) m[ad] = {6'h00, d[1:0]};
    end else m[ad] = (m[ad] & ~wm[ad]) | (d & wm[ad]);
  endtask

  task automatic rd(logic [7:0] ad);
    @(posedge core_clk);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  function automatic logic [3:0] dec(logic [7:0] c);
    return c[2] ? (4'h1 << c[1:0]) : 4'h0;
  endfunction

  task automatic check_outs;
    #1 chk("s1rx", dec(m[8'hba] >> 4), s1rx);
    chk("s1tx", dec(m[8'hba]), s1tx);
    chk("s2rx", dec(m[8'hbb] >> 4), s2rx);
    chk("s2tx", dec(m[8'hbb]), s2tx);
    chk("flash", {m[8'hbe], m[8'hbd], m[8'hbc][7:4], 12'h000}, flash_addr);
    chk("io", {m[8'hd1], m[8'hd0][7:4], 4'h0}, io_base);
    chk("pstate", m[8'hc4][1:0], pstate);
    chk("hosten", m[8'hd2][0], host_en);
    chk("slowsel", m[8'hd2][2], slow_sel);
    chk("scmd", m[8'hd3], slave_cmd);
    chk("sh1", {m[8'hd4][7:1], m[8'hd4][0]}, {sh1_a, sh1_w});
    chk("sh2", {m[8'hd5][7:1], m[8'hd5][0]}, {sh2_a, sh2_w});
  endtask

  // one pin change, then watch a bounded window for the pulse
  task automatic gpi_try(logic [7:0] sel, logic [7:0] pins, int e, int ie);
    wr(8'he0, sel);
    gpi_pins <= pins;
    n = 0;
    repeat (8) begin
      @(posedge core_clk);
      #1 if (gpi_event !== 8'h00) n += (gpi_event === 8'h01) ? 1 : 8;
    end
    chk("gpi_event", e, n);
    chk("irq", e & ie, irq);
    rd(8'hf0);
    chk("status", e, v);
    wr(8'hf1, 8'h03);
    @(posedge core_clk);
    #1 chk("irq_clr", 0, irq);
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // watchdog: the whole sequence needs well under 6000 cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    wrap_up();
  end

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    {srst, reg_wr, reg_rd, smb_alert} = 4'h8;
    {reg_addr, reg_wdata, gpi_pins} = 24'h000000;
    seed = 1010;
    foreach (m[i]) {m[i], wm[i]} = 16'h0000;
    foreach (alist[i]) if (i < 12) wm[alist[i]] = 8'hff;
    {wm[8'hbc], wm[8'hd0], wm[8'hd2]} = 24'hf0f00f;
    {m[8'hc0], m[8'hc2], m[8'hd0], m[8'hd6]} = 32'h0102013c;
    repeat (6) @(posedge core_clk);
    srst <= 1'b0;
    foreach (alist[i]) begin
      rd(alist[i]);
      chk("reset", m[alist[i]], v);
    end
    check_outs();
    $display("test reset values done");
    repeat (60) begin
      a = alist[$unsigned($random(seed)) % 19];
      wr(a, 8'($random(seed)));
      rd(a);
      chk("readback", m[a], v);
      check_outs();
    end
    for (int c = 0; c < 8; c++) begin
      wr(8'hba, {1'b0, 3'(c), 1'b1, 3'(7 - c)});
      wr(8'hbb, {1'b1, 3'(7 - c), 1'b0, 3'(c)});
      check_outs();
    end
    wr(8'hf1, 8'hff);
    for (int k = 0; k < 4; k++) begin
      wr(8'hc4, 8'(k));
      check_outs();
    end
    rd(8'hf0);
    chk("pstate_evt", 1, v[1]);
    $display("test register access done");
    smb_alert <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      wr(8'hd2, {4'h0, 1'(k >> 1), 1'b0, 1'(k), 1'b0});
      repeat (4) @(posedge core_clk);
      chk("smi", k == 1, sys_int);
      chk("sci", k == 3, cfg_int);
    end
    for (int k = 1; k >= 0; k--) begin
      wr(8'hd2, k ? 8'h04 : 8'h00);
      repeat (10) @(posedge core_clk);
      n = 0;
      repeat (400) begin
        @(posedge core_clk);
        #1 if (slow_tick === 1'b1) n++;
      end
      chk("slow_tick", k, k ? (n >= 2) : (n != 0));
    end
    $display("test alert and slow clock done");
    wr(8'hf1, 8'hff);
    wr(8'hf2, 8'h01);
    gpi_try(8'h01, 8'h01, 1, 1);
    gpi_try(8'h01, 8'h00, 0, 1);
    gpi_try(8'h00, 8'h01, 0, 1);
    gpi_try(8'h00, 8'h00, 1, 1);
    wr(8'hf2, 8'h00);
    gpi_try(8'h01, 8'h01, 1, 0);
    $display("test input events done");
    wrap_up();
  end
endmodule
